// ===== core/aelss_top.sv
// Exposure-loop luma smoothing, refresh interval and step control, context A
`timescale 1ns/10ps
module aelss_top
	import aelss_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	// Context and measurement
	input wire logic ctxASel,
	input wire logic lumaValid,
	input wire logic [LUMA_W-1:0] lumaMeas,
	input wire logic [LUMA_W-1:0] lumaTarget,
	// Exposure loop results
	output logic [LUMA_W-1:0] avgLuma,
	output logic lumaUpdate,
	output logic [LUMA_W-1:0] stepLuma,
	output logic adjValid
);
	logic [DATA_W-1:0] speedReg_q;
	logic [DATA_W-1:0] rdata_q;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic [1:0] frameCnt_q;
	logic lumaUpdate_q;
	logic adjValid_q;
	logic [LUMA_W-1:0] stepLuma_q;
	logic [LUMA_W-1:0] target_q;
	logic [1:0] interval;
	logic [2:0] smthCode;
	logic refresh;
	logic frameIn;
	logic signed [ACC_W:0] accGap;
	aelss_step_if stepIf ();

	// ****************************************************************
	// Register file
	// ****************************************************************
	// Whole word stored, reserved bits included
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			speedReg_q <= SPEED_RST;
		end else if (regWr && regAddr == SPEED_OFF) begin
			speedReg_q <= regWdata;
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_q <= 16'h0000;
		end else if (regRd && regAddr == SPEED_OFF) begin
			rdata_q <= speedReg_q;
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign regRdata = rdata_q;

	// Field decode; reserved bits feed nothing
	assign interval = speedReg_q[INTV_MSB:INTV_LSB];
	assign smthCode = speedReg_q[SMTH_MSB:SMTH_LSB];
	assign stepIf.code = aelss_step_t'(speedReg_q[STEP_MSB:STEP_LSB]);

	// ****************************************************************
	// Refresh interval
	// ****************************************************************
	// Only frames seen in context A count
	assign frameIn = lumaValid && ctxASel;
	assign refresh = frameIn && (interval == 2'h0 || frameCnt_q == interval - 2'h1);

	// Frame counter wraps on every refresh
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			frameCnt_q <= 2'h0;
		end else if (refresh) begin
			frameCnt_q <= 2'h0;
		end else if (frameIn) begin
			frameCnt_q <= frameCnt_q + 2'h1;
		end
	end

	// ****************************************************************
	// Time-averaged luma
	// ****************************************************************
	// Buffer moves by 1/2^k of the gap to the new measurement
	assign accGap = $signed({1'b0, lumaMeas, 7'h00}) - $signed({1'b0, acc_q});
	assign acc_d = ACC_W'($signed({1'b0, acc_q}) + (accGap >>> smthCode));

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			acc_q <= 15'h0000;
		end else if (refresh) begin
			acc_q <= acc_d;
		end
	end
	assign avgLuma = acc_q[ACC_W-1:ACC_FRAC];

	// Refresh marker and target capture
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lumaUpdate_q <= 1'b0;
			target_q <= 8'h00;
		end else begin
			lumaUpdate_q <= refresh;
			if (refresh) begin
				target_q <= lumaTarget;
			end
		end
	end
	assign lumaUpdate = lumaUpdate_q;

	// ****************************************************************
	// Adjustment step
	// ****************************************************************
	assign stepIf.curLuma = avgLuma;
	assign stepIf.tgtLuma = target_q;

	aelss_step_calc uStep (
		.stepIf(stepIf.calc)
	);

	// One adjustment per refreshed luma
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			adjValid_q <= 1'b0;
			stepLuma_q <= 8'h00;
		end else begin
			adjValid_q <= lumaUpdate_q;
			if (lumaUpdate_q) begin
				stepLuma_q <= stepIf.stepLuma;
			end
		end
	end
	assign adjValid = adjValid_q;
	assign stepLuma = stepLuma_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	property p_step_issue;
		lumaUpdate_q |=> adjValid_q && stepLuma_q == $past(stepIf.stepLuma);
	endproperty
	a_step_issue: assert property (p_step_issue) else $error("step not issued");

	property p_code0;
		(stepIf.code == STEP_Q_DN_E_UP && stepIf.tgtLuma > stepIf.curLuma)
			|-> stepIf.stepLuma == 8'(stepIf.curLuma + ((stepIf.tgtLuma - stepIf.curLuma) >> 3));
	endproperty
	a_code0: assert property (p_code0) else $error("code 0 upward step wrong");

	property p_half;
		(stepIf.code == STEP_HALF && stepIf.tgtLuma < stepIf.curLuma)
			|-> stepIf.stepLuma <= stepIf.curLuma && stepIf.stepLuma >= stepIf.tgtLuma;
	endproperty
	a_half: assert property (p_half) else $error("half step out of range");

	property p_three_q;
		(stepIf.code == STEP_3QUARTER && stepIf.tgtLuma > stepIf.curLuma)
			|-> stepIf.stepLuma == 8'(stepIf.curLuma
			+ ((stepIf.tgtLuma - stepIf.curLuma) >> 1) + ((stepIf.tgtLuma - stepIf.curLuma) >> 2));
	endproperty
	a_three_q: assert property (p_three_q) else $error("three quarter step wrong");

	property p_full;
		aelss_is_full(stepIf.code) |-> stepIf.stepLuma == stepIf.tgtLuma;
	endproperty
	a_full: assert property (p_full) else $error("full step misses target");

	property p_interval;
		(frameIn && interval != 2'h0 && frameCnt_q != interval - 2'h1) |=> !lumaUpdate_q;
	endproperty
	a_interval: assert property (p_interval) else $error("early luma refresh");

	property p_every;
		(frameIn && interval == 2'h0) |=> lumaUpdate_q;
	endproperty
	a_every: assert property (p_every) else $error("missed refresh");

	property p_smooth_bound;
		(refresh && smthCode != 3'h0 && lumaMeas > avgLuma) |=> avgLuma <= $past(lumaMeas);
	endproperty
	a_smooth_bound: assert property (p_smooth_bound) else $error("average overshoots");

	property p_pass;
		(refresh && smthCode == 3'h0) |=> avgLuma == $past(lumaMeas);
	endproperty
	a_pass: assert property (p_pass) else $error("code 0 not passthrough");

	property p_ctxb;
		!ctxASel |=> $stable(avgLuma) && !lumaUpdate_q;
	endproperty
	a_ctxb: assert property (p_ctxb) else $error("changed outside context A");

	property p_readback;
		(regRd && regAddr == SPEED_OFF && !regWr) |=> regRdata == $past(speedReg_q);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	c_full: cover property (adjValid_q && aelss_is_full(stepIf.code));
	c_slow: cover property (refresh && smthCode == 3'h7);
	c_interval3: cover property (lumaUpdate_q && interval == 2'h3);
	c_ctxb: cover property (lumaValid && !ctxASel);
	c_pass: cover property (refresh && smthCode == 3'h0);
endmodule : aelss_top

// ===== core/aelss_pkg.sv
// Constants and types shared by the exposure-loop luma smoothing and step block
package aelss_pkg;
	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam logic [9:0] SPEED_OFF = 10'h22f;
	localparam logic [15:0] SPEED_RST = 16'hdf20;
	// ********************************************************************
	// Field positions of the speed and sensitivity register
	// ********************************************************************
	localparam int STEP_LSB = 6;
	localparam int STEP_MSB = 8;
	localparam int INTV_LSB = 3;
	localparam int INTV_MSB = 4;
	localparam int SMTH_LSB = 0;
	localparam int SMTH_MSB = 2;
	// ********************************************************************
	// Data widths
	// ********************************************************************
	localparam int LUMA_W = 8;
	localparam int ACC_FRAC = 7;
	localparam int ACC_W = LUMA_W + ACC_FRAC;
	// Step codes of the adjustment fraction
	typedef enum logic [2:0] {
		STEP_Q_DN_E_UP = 3'h0,
		STEP_QUARTER = 3'h1,
		STEP_HALF = 3'h2,
		STEP_H_DN_Q_UP = 3'h3,
		STEP_FULL = 3'h4,
		STEP_3QUARTER = 3'h5,
		STEP_UNDOC = 3'h6,
		STEP_RSVD = 3'h7
	} aelss_step_t;
	// Codes that close the whole gap
	function automatic logic aelss_is_full(input aelss_step_t code);
		aelss_is_full = (code == STEP_FULL) || (code == STEP_UNDOC) || (code == STEP_RSVD);
	endfunction : aelss_is_full
endpackage : aelss_pkg

// ===== core/aelss_step_if.sv
// Carrier between the averaging core and the step calculator
`timescale 1ns/10ps
interface aelss_step_if;
	import aelss_pkg::*;
	aelss_step_t code;
	logic [LUMA_W-1:0] curLuma;
	logic [LUMA_W-1:0] tgtLuma;
	logic [LUMA_W-1:0] stepLuma;
	modport calc (input code, input curLuma, input tgtLuma, output stepLuma);
	modport user (output code, output curLuma, output tgtLuma, input stepLuma);
endinterface : aelss_step_if

// ===== core/aelss_step_calc.sv
// Adjustment step calculator: closes a fraction of the luma gap
`timescale 1ns/10ps
module aelss_step_calc
	import aelss_pkg::*;
(
	// Step request and result
	aelss_step_if.calc stepIf
);
	logic signed [LUMA_W:0] gap;
	logic signed [LUMA_W:0] delta;
	logic goingUp;
	logic [LUMA_W:0] stepLuma;

	// Signed gap from averaged luma to target
	assign gap = $signed({1'b0, stepIf.tgtLuma}) - $signed({1'b0, stepIf.curLuma});
	assign goingUp = (gap > 0);

	// Fraction of the gap selected by the step code
	always_comb begin
		case (stepIf.code)
			STEP_Q_DN_E_UP: delta = goingUp ? (gap >>> 3) : (gap >>> 2);
			STEP_H_DN_Q_UP: delta = goingUp ? (gap >>> 2) : (gap >>> 1);
			STEP_QUARTER: delta = gap >>> 2;
			STEP_HALF: delta = gap >>> 1;
			STEP_3QUARTER: delta = (gap >>> 1) + (gap >>> 2);
			default: delta = gap;
		endcase
	end

	// Luma the controller moves to in this adjustment
	assign stepLuma = 9'($signed({1'b0, stepIf.curLuma}) + delta);
	assign stepIf.stepLuma = stepLuma[LUMA_W-1:0];
endmodule : aelss_step_calc

// ===== verification/aelss_tb.sv
// Self-checking bench for the exposure-loop luma smoothing and step block
`timescale 1ns/10ps
module testbench;
	import aelss_pkg::*;
	// ********************************************************************
	// Stimulus, model state and design
	// ********************************************************************
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic ctxASel = 1'b1;
	logic lumaValid = 1'b0;
	logic [LUMA_W-1:0] lumaMeas = '0;
	logic [LUMA_W-1:0] lumaTarget = '0;
	logic [DATA_W-1:0] regRdata;
	logic [LUMA_W-1:0] avgLuma, stepLuma;
	logic lumaUpdate, adjValid;
	logic rdPend = 1'b0;
	logic [31:0] rnd = 32'hecc9;
	logic [15:0] cfg = 16'hdf20;
	logic [15:0] rdQ[$];
	logic [7:0] avgQ[$], stepQ[$];
	int errTotal = 0, nTests = 0, cycles = 0, acc = 0, cnt = 0;
	// Clock at 20 MHz
	always #25 clk_sys = ~clk_sys;
	aelss_top u_aelss_top (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.ctxASel(ctxASel), .lumaValid(lumaValid), .lumaMeas(lumaMeas),
		.lumaTarget(lumaTarget), .avgLuma(avgLuma), .lumaUpdate(lumaUpdate),
		.stepLuma(stepLuma), .adjValid(adjValid));
	// Pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Luma the adjustment moves to, floor shifts on the signed gap
	function automatic logic [7:0] stepOf(input int a, input int t, input logic [2:0] c);
		int g, f;
		g = t - a;
		case (c)
			3'h0: f = (g < 0) ? g >>> 2 : g >>> 3;
			3'h1: f = g >>> 2;
			3'h2: f = g >>> 1;
			3'h3: f = (g < 0) ? g >>> 1 : g >>> 2;
			3'h5: f = (g >>> 1) + (g >>> 2);
			default: f = g;
		endcase
		return 8'(a + f);
	endfunction : stepOf
	task automatic chkReg(input logic [15:0] e, input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			errTotal++;
			$display("[FAIL] regRdata exp %h got %h", e, g);
		end
	endtask : chkReg
	task automatic chkLuma(input string n, input logic [7:0] e, input logic [7:0] g);
		nTests++;
		if (g !== e) begin
			errTotal++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chkLuma
	// One register cycle; reads note the expected data
	task automatic regAcc(input logic wr, input logic [9:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWr <= wr;
		regRd <= !wr;
		regAddr <= a;
		regWdata <= d;
		if (wr && a == SPEED_OFF)
			cfg = d;
		if (!wr)
			rdQ.push_back((a == SPEED_OFF) ? cfg : 16'h0);
		@(posedge clk_sys);
		regWr <= 1'b0;
		regRd <= 1'b0;
	endtask : regAcc
	// One frame measurement, context B allowed at random
	task automatic frame(input logic allowB);
		logic ctx;
		int m;
		rnd = lfsr(rnd);
		ctx = allowB ? (rnd[16] | rnd[17]) : 1'b1;
		m = rnd[7:0];
		@(posedge clk_sys);
		ctxASel <= ctx;
		lumaValid <= 1'b1;
		lumaMeas <= rnd[7:0];
		lumaTarget <= rnd[15:8];
		if (ctx) begin
			if (cfg[4:3] == 2'h0 || cnt == cfg[4:3] - 1) begin
				cnt = 0;
				acc = acc + (((m << 7) - acc) >>> cfg[2:0]);
				avgQ.push_back(8'(acc >> 7));
				stepQ.push_back(stepOf(acc >> 7, rnd[15:8], cfg[8:6]));
			end else
				cnt++;
		end
	endtask : frame
	task automatic giveVerdict;
		$display("Checks %0d, mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : giveVerdict
	// ********************************************************************
	// Monitor, timeout and main sequence
	// ********************************************************************
	always @(posedge clk_sys) begin
		rdPend <= regRd;
		cycles++;
		if (cycles == 3000) begin
			errTotal++;
			giveVerdict();
		end
	end
	// Oldest note is compared whenever a result shows
	always @(negedge clk_sys) begin
		if (!srst) begin
			if (rdPend)
				chkReg(rdQ.pop_front(), regRdata);
			else
				chkReg(16'h0, regRdata);
			if (lumaUpdate)
				chkLuma("avgLuma", avgQ.size() ? avgQ.pop_front() : 8'hxx, avgLuma);
			if (adjValid)
				chkLuma("stepLuma", stepQ.size() ? stepQ.pop_front() : 8'hxx, stepLuma);
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		regAcc(1'b0, SPEED_OFF, 16'h0);
		regAcc(1'b1, SPEED_OFF, 16'hffff);
		regAcc(1'b1, 10'h22e, 16'h1234);
		regAcc(1'b0, 10'h22e, 16'h0);
		regAcc(1'b0, SPEED_OFF, 16'h0);
		// Every step code at every interval, smoothing codes spread, reserved bits random
		for (int i = 0; i < 32; i++) begin
			rnd = lfsr(rnd);
			regAcc(1'b1, SPEED_OFF, {rnd[15:9], 3'(i), rnd[5], 2'(i >> 3), 3'(i * 5)});
			regAcc(1'b0, SPEED_OFF, 16'h0);
			repeat (6) frame(1'b1);
			while (cnt != 0)
				frame(1'b0);
			@(posedge clk_sys);
			lumaValid <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (3) @(posedge clk_sys);
		chkLuma("pending", 8'h0, 8'(avgQ.size() + stepQ.size()));
		giveVerdict();
	end
endmodule : testbench
